/* File: core/hpf_regs.svh */
`ifndef HPF_REGS_SVH
`define HPF_REGS_SVH

// Sample and coefficient formats
`define HPF_SAMPLE_W 16
`define HPF_COEF_W 24
`define HPF_COEF_FRAC 22
`define HPF_ACC_W 56
`define HPF_STATE_W 32

// Coefficients in signed Q1.22, rounded from the tabulated values
// 8 kHz
`define HPF_B0_8K 24'sh3F4B07
`define HPF_B1_8K 24'sh8169F2
`define HPF_A1_8K 24'sh7E940E
`define HPF_A2_8K 24'shC167F3
// 16 kHz
`define HPF_B0_16K 24'sh3FA543
`define HPF_B1_16K 24'sh80B57A
`define HPF_A1_16K 24'sh7F4A05
`define HPF_A2_16K 24'shC0B4F9
// 32 kHz
`define HPF_B0_32K 24'sh3FD291
`define HPF_B1_32K 24'sh805ADD
`define HPF_A1_32K 24'sh7FA503
`define HPF_A2_32K 24'shC05ABD
// 48 kHz
`define HPF_B0_48K 24'sh3FE1B3
`define HPF_B1_48K 24'sh803C9B
`define HPF_A1_48K 24'sh7FC357
`define HPF_A2_48K 24'shC03C8C

// Rate select codes
`define HPF_RATE_8K 2'h0
`define HPF_RATE_16K 2'h1
`define HPF_RATE_32K 2'h2
`define HPF_RATE_48K 2'h3

`endif

/* File: core/hpf_pkg.sv */
`include "hpf_regs.svh"
package hpf_pkg;
  typedef logic signed [`HPF_COEF_W-1:0] hpf_coef_t;
  typedef logic signed [`HPF_STATE_W-1:0] hpf_state_t;
  typedef logic signed [`HPF_ACC_W-1:0] hpf_acc_t;
  typedef enum logic [1:0] {HPF_IDLE, HPF_RUN} hpf_state_e_t;
endpackage : hpf_pkg

/* File: core/hpf_coef_rom.sv */
`timescale 1ns/1ps
`include "hpf_regs.svh"
module hpf_coef_rom
  import hpf_pkg::*;
(
  input wire logic [1:0] rate_sel,
  output hpf_coef_t b0,
  output hpf_coef_t b1,
  output hpf_coef_t a1,
  output hpf_coef_t a2
);
  // b2 equals b0 for every rate, so it is not stored
  always_comb begin
    case (rate_sel)
      `HPF_RATE_8K: begin
        b0 = `HPF_B0_8K;
        b1 = `HPF_B1_8K;
        a1 = `HPF_A1_8K;
        a2 = `HPF_A2_8K;
      end
      `HPF_RATE_16K: begin
        b0 = `HPF_B0_16K;
        b1 = `HPF_B1_16K;
        a1 = `HPF_A1_16K;
        a2 = `HPF_A2_16K;
      end
      `HPF_RATE_32K: begin
        b0 = `HPF_B0_32K;
        b1 = `HPF_B1_32K;
        a1 = `HPF_A1_32K;
        a2 = `HPF_A2_32K;
      end
      default: begin
        b0 = `HPF_B0_48K;
        b1 = `HPF_B1_48K;
        a1 = `HPF_A1_48K;
        a2 = `HPF_A2_48K;
      end
    endcase
  end
endmodule : hpf_coef_rom

/* File: core/hpf_biquad.sv */
// How it works
// - Accept samples at 8, 16, 32 or 48 kHz; rate input picks coefficients.
// - Each sample passes a second-order recursive high-pass near 20 Hz.
// - 8 and 16 kHz use their tabulated three feedforward, two feedback values.
// - 32 and 48 kHz use their tabulated coefficient sets.
`timescale 1ns/1ps
`include "hpf_regs.svh"
module hpf_biquad
  import hpf_pkg::*;
#(
  parameter int SAMPLE_W = `HPF_SAMPLE_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] rate_sel,
  input wire logic in_valid,
  input wire logic signed [SAMPLE_W-1:0] in_sample,
  output logic out_valid,
  output logic signed [SAMPLE_W-1:0] highpass_output_sample,
  output logic [1:0] active_rate
);

  // ----------------------------------------
  // Coefficient selection
  // ----------------------------------------
  hpf_coef_t b0;
  hpf_coef_t b1;
  hpf_coef_t a1;
  hpf_coef_t a2;
  logic [1:0] rate;
  logic [1:0] rom_rate;

  // Rate is latched on each sample so a mid-stream change is clean
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate <= `HPF_RATE_8K;
    end else if (in_valid) begin
      rate <= rate_sel;
    end
  end
  assign active_rate = rate;
  // Coefficients follow the incoming sample's rate on the take edge
  assign rom_rate = in_valid ? rate_sel : rate;

  hpf_coef_rom u_rom (
    .rate_sel(rom_rate),
    .b0(b0),
    .b1(b1),
    .a1(a1),
    .a2(a2)
  );

  // ----------------------------------------
  // Filter state
  // ----------------------------------------
  // Sixteen extra state bits keep the slow poles from drifting
  logic signed [SAMPLE_W-1:0] x1;
  logic signed [SAMPLE_W-1:0] x2;
  hpf_state_t y1;
  hpf_state_t y2;

  function automatic hpf_acc_t mul(input hpf_coef_t c, input hpf_state_t v);
    mul = hpf_acc_t'(c) * hpf_acc_t'(v);
  endfunction : mul

  function automatic hpf_state_t ext(input logic signed [SAMPLE_W-1:0] s);
    ext = hpf_state_t'(s) <<< (`HPF_STATE_W - SAMPLE_W);
  endfunction : ext

  // ----------------------------------------
  // Difference equation
  // ----------------------------------------
  hpf_acc_t acc;
  hpf_acc_t acc_shift;
  hpf_state_t next_y;
  logic signed [SAMPLE_W-1:0] next_out;
  localparam int SHIFT_OUT = `HPF_STATE_W - SAMPLE_W;
  localparam hpf_state_t YMAX = {1'b0, {(`HPF_STATE_W-1){1'b1}}};
  localparam hpf_state_t YMIN = {1'b1, {(`HPF_STATE_W-1){1'b0}}};

  // y = b0 x + b1 x1 + b0 x2 + a1 y1 + a2 y2, feedback added
  assign acc = mul(b0, ext(in_sample)) + mul(b1, ext(x1)) + mul(b0, ext(x2))
             + mul(a1, y1) + mul(a2, y2);
  assign acc_shift = acc >>> `HPF_COEF_FRAC;
  // Saturate to the state width
  assign next_y = (acc_shift > hpf_acc_t'(YMAX)) ? YMAX :
                  (acc_shift < hpf_acc_t'(YMIN)) ? YMIN :
                  acc_shift[`HPF_STATE_W-1:0];
  assign next_out = next_y[`HPF_STATE_W-1 -: SAMPLE_W];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      x1 <= '0;
      x2 <= '0;
      y1 <= '0;
      y2 <= '0;
    end else if (in_valid) begin
      x1 <= in_sample;
      x2 <= x1;
      y1 <= next_y;
      y2 <= y1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      highpass_output_sample <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        highpass_output_sample <= next_out;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_take;
    in_valid;
  endsequence

  sequence s_idle;
    !in_valid;
  endsequence

  sequence s_back_to_back;
    in_valid ##1 in_valid;
  endsequence

  out_follows_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |=> out_valid)
    else $error("output valid did not follow input");

  no_spurious_a: assert property (@(posedge ref_clk) disable iff (rst)
    !in_valid |=> !out_valid)
    else $error("output valid without input");

  hold_out_a: assert property (@(posedge ref_clk) disable iff (rst)
    !in_valid |=> $stable(highpass_output_sample))
    else $error("output changed without sample");

  rate_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
    in_valid |=> active_rate == $past(rate_sel))
    else $error("rate not latched");

  coef_8k_a: assert property (@(posedge ref_clk) disable iff (rst)
    (in_valid && rate_sel == `HPF_RATE_8K) |-> b0 == `HPF_B0_8K && a1 == `HPF_A1_8K)
    else $error("wrong 8 kHz coefficients");

  coef_16k_a: assert property (@(posedge ref_clk) disable iff (rst)
    (in_valid && rate_sel == `HPF_RATE_16K) |-> b1 == `HPF_B1_16K && a2 == `HPF_A2_16K)
    else $error("wrong 16 kHz coefficients");

  coef_48k_a: assert property (@(posedge ref_clk) disable iff (rst)
    (in_valid && rate_sel == `HPF_RATE_48K) |-> a1 == `HPF_A1_48K && b0 == `HPF_B0_48K)
    else $error("wrong 48 kHz coefficients");

  coef_32k_a: assert property (@(posedge ref_clk) disable iff (rst)
    (in_valid && rate_sel == `HPF_RATE_32K) |-> a2 == `HPF_A2_32K && b1 == `HPF_B1_32K)
    else $error("wrong 32 kHz coefficients");

  state_shift_a: assert property (@(posedge ref_clk) disable iff (rst)
    in_valid ##1 in_valid |=> y2 == $past(y1) && x2 == $past(x1))
    else $error("delay line did not shift");

  // ----------------------------------------
  // Datapath checks
  // ----------------------------------------
  x_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |=> x1 == $past(in_sample) && x2 == $past(x1))
    else $error("input delay line did not capture");

  y_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |=> y1 == $past(next_y) && y2 == $past(y1))
    else $error("output delay line did not capture");

  out_from_state_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |=> highpass_output_sample == SAMPLE_W'(y1 >>> SHIFT_OUT))
    else $error("output is not the top of the state");

  state_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_idle |=> $stable(x1) && $stable(x2) && $stable(y1) && $stable(y2))
    else $error("filter state moved without sample");

  rate_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_idle |=> $stable(active_rate))
    else $error("rate changed without sample");

  rom_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_idle |-> rom_rate == active_rate)
    else $error("idle coefficients not from held rate");

  rate_take_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |-> rom_rate == rate_sel)
    else $error("coefficients not from incoming rate");

  out_train_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_back_to_back |=> out_valid && $past(out_valid))
    else $error("back to back samples lost an output");

  // ----------------------------------------
  // Coefficient checks
  // ----------------------------------------
  coef_8k_b_a: assert property (@(posedge ref_clk) disable iff (rst)
    (in_valid && rate_sel == `HPF_RATE_8K) |-> b1 == `HPF_B1_8K && a2 == `HPF_A2_8K)
    else $error("wrong 8 kHz b1 or a2");

  coef_16k_b_a: assert property (@(posedge ref_clk) disable iff (rst)
    (in_valid && rate_sel == `HPF_RATE_16K) |-> b0 == `HPF_B0_16K && a1 == `HPF_A1_16K)
    else $error("wrong 16 kHz b0 or a1");

  coef_32k_b_a: assert property (@(posedge ref_clk) disable iff (rst)
    (in_valid && rate_sel == `HPF_RATE_32K) |-> b0 == `HPF_B0_32K && a1 == `HPF_A1_32K)
    else $error("wrong 32 kHz b0 or a1");

  coef_48k_b_a: assert property (@(posedge ref_clk) disable iff (rst)
    (in_valid && rate_sel == `HPF_RATE_48K) |-> b1 == `HPF_B1_48K && a2 == `HPF_A2_48K)
    else $error("wrong 48 kHz b1 or a2");

endmodule : hpf_biquad

/* File: sim/hpf_src.sv */
`timescale 1ns/1ps
module hpf_src (
  input wire logic ref_clk,
  input wire logic en,
  input wire logic alt,
  input wire logic [1:0] gap,
  input wire logic signed [15:0] level,
  output logic in_valid,
  output logic signed [15:0] in_sample
);
  logic [1:0] cnt = 2'h0;
  logic neg = 1'b0;
  logic fire;
  assign fire = en && cnt == 2'h0;
  initial in_valid = 1'b0;
  initial in_sample = 16'sh0;
  // Idle data toggles so stale values are never mistaken for samples
  always @(negedge ref_clk) begin
    in_valid <= fire;
    in_sample <= fire ? ((alt && neg) ? -level : level) : ~in_sample;
    if (fire) begin
      cnt <= gap;
      neg <= ~neg;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end
  end
endmodule : hpf_src

/* File: sim/test_input_highpass_20hz_biquad.sv */
`timescale 1ns/1ps
`include "hpf_regs.svh"
module test_input_highpass_20hz_biquad;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] rate_sel = 2'h0;
  logic en = 1'b0;
  logic alt = 1'b0;
  logic [1:0] gap = 2'h0;
  logic signed [15:0] level = 16'sh0;
  logic in_valid, out_valid, was_valid;
  logic signed [15:0] in_sample, highpass_output_sample;
  logic [1:0] active_rate;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int e;
  // Tabulated b0, b1, a1, a2 per rate, and the stored Q1.22 words
  real tab[4][4] = '{
    '{0.988954248067140, -1.977908496134280, 1.977786483776764, -0.978030508491796},
    '{0.994461788958195, -1.988923577916390, 1.988892905899653, -0.988954249933127},
    '{0.997227049904470, -1.994454099808940, 1.994446410541927, -0.994461789075954},
    '{0.998150511190452, -1.996301022380904, 1.996297601769122, -0.996304442992686}};
  logic signed [23:0] cf[4][4] = '{
    '{`HPF_B0_8K, `HPF_B1_8K, `HPF_A1_8K, `HPF_A2_8K},
    '{`HPF_B0_16K, `HPF_B1_16K, `HPF_A1_16K, `HPF_A2_16K},
    '{`HPF_B0_32K, `HPF_B1_32K, `HPF_A1_32K, `HPF_A2_32K},
    '{`HPF_B0_48K, `HPF_B1_48K, `HPF_A1_48K, `HPF_A2_48K}};
  real x1, x2, y1, y2, y;
  always #12.5 ref_clk = ~ref_clk;
  hpf_src src_u (.ref_clk(ref_clk), .en(en), .alt(alt), .gap(gap), .level(level),
    .in_valid(in_valid), .in_sample(in_sample));
  hpf_biquad dut_u (.ref_clk(ref_clk), .rst(rst), .rate_sel(rate_sel), .in_valid(in_valid),
    .in_sample(in_sample), .out_valid(out_valid),
    .highpass_output_sample(highpass_output_sample), .active_rate(active_rate));
  function automatic real q(input logic signed [23:0] c);
    q = real'(c) / (2.0 ** `HPF_COEF_FRAC);
  endfunction : q
  function automatic int to_q(input real v);
    to_q = $rtoi(v * (2.0 ** `HPF_COEF_FRAC) + (v >= 0.0 ? 0.5 : -0.5));
  endfunction : to_q
  task automatic check_coefs;
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 4; k++) begin
        check(cf[r][k], to_q(tab[r][k]), cf[r][k] == to_q(tab[r][k]));
      end
    end
  endtask : check_coefs
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input bit ok);
    comparisons++;
    if (!ok) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // ----------------
  // Reference model
  // ----------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_total++;
      end_sim();
    end
    if (rst) begin
      x1 = 0.0;
      x2 = 0.0;
      y1 = 0.0;
      y2 = 0.0;
      y = 0.0;
      was_valid = 1'b0;
    end else begin
      check(out_valid, was_valid, out_valid === was_valid);
      if (out_valid === 1'b1) begin
        e = $rtoi(y + (y >= 0.0 ? 0.5 : -0.5));
        check(highpass_output_sample, e, !$isunknown(highpass_output_sample) &&
          highpass_output_sample - e <= 2 && e - highpass_output_sample <= 2);
        check(active_rate, rate_sel, active_rate === rate_sel);
      end
      if (in_valid) begin
        y = q(cf[rate_sel][0]) * (in_sample + x2) + q(cf[rate_sel][1]) * x1
          + q(cf[rate_sel][2]) * y1 + q(cf[rate_sel][3]) * y2;
        x2 = x1;
        x1 = in_sample;
        y2 = y1;
        y1 = y;
      end
      was_valid = in_valid;
    end
  end
  task automatic run(input logic [1:0] r, input logic a, input logic [1:0] g,
    input logic signed [15:0] lv);
    @(negedge ref_clk) rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(out_valid, 0, out_valid === 1'b0 && highpass_output_sample === 16'sh0);
    rst = 1'b0;
    {rate_sel, alt, gap, level, en} <= {r, a, g, lv, 1'b1};
    repeat (200) @(negedge ref_clk);
    en <= 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask : run
  initial begin
    repeat (5) @(negedge ref_clk);
    check(active_rate, 0, active_rate === 2'h0 && out_valid === 1'b0);
    check_coefs();
    for (int r = 0; r < 4; r++) run(r[1:0], 1'b0, 2'h0, 16'sh2EE0);
    run(2'h3, 1'b1, 2'h2, -16'sh1F40);
    run(2'h0, 1'b1, 2'h1, 16'sh1F40);
    end_sim();
  end
endmodule : test_input_highpass_20hz_biquad
